//--- include/urs_defs.svh
// Constants for the UART register select map: offsets, gating bits,
// write masks and reset values.
// Assumes inclusion by bare name from files that need the figures.
`ifndef URS_DEFS_SVH
`define URS_DEFS_SVH

// Register offsets on the three address lines
`define URS_OFS_DATA 3'h0
`define URS_OFS_IER 3'h1
`define URS_OFS_IIR 3'h2
`define URS_OFS_LCR 3'h3
`define URS_OFS_MCR 3'h4
`define URS_OFS_LSR 3'h5
`define URS_OFS_MSR 3'h6
`define URS_OFS_SPR 3'h7

// Gating bits and key values
`define URS_LCR_DIVISOR_BIT 7
`define URS_LCR_EXT_KEY 8'hBF
`define URS_EFR_ENH_BIT 4
`define URS_MCR_TRIG_EN_BIT 6
`define URS_MCR_RDY_EN_BIT 2
`define URS_MCR_LOOP_BIT 4
`define URS_FCR_ENABLE_BIT 0

// Bits that only move while enhanced functions are on
`define URS_IER_ENH_MASK 8'hF0
`define URS_FCR_ENH_MASK 8'h30
`define URS_MCR_ENH_MASK 8'h80
// Clear bits of the FIFO control that return to zero by themselves
`define URS_FCR_SELFCLR_MASK 8'h06

// Reset values and fill patterns
`define URS_RESET_BYTE 8'h00
`define URS_RESET_DIVISOR 16'h0000
`define URS_FRDY_PAD 2'h0

// Channel indexes
`define URS_CHAN_A 0
`define URS_CHAN_B 1

`endif

//--- include/urs_pkg.sv
// Types shared by the UART register select map.
// Assumes nothing beyond a SystemVerilog compiler.
package urs_pkg;

  // Register reached by one access
  typedef enum logic [17:0] {
    TGT_DATA = 18'h00001,
    TGT_IER = 18'h00002,
    TGT_IIR_FCR = 18'h00004,
    TGT_LCR = 18'h00008,
    TGT_MCR = 18'h00010,
    TGT_LSR = 18'h00020,
    TGT_MSR = 18'h00040,
    TGT_SPR = 18'h00080,
    TGT_DLL = 18'h00100,
    TGT_DLH = 18'h00200,
    TGT_EFR = 18'h00400,
    TGT_FLOW_ON_CHAR_1 = 18'h00800,
    TGT_FLOW_ON_CHAR_2 = 18'h01000,
    TGT_FLOW_OFF_CHAR_1 = 18'h02000,
    TGT_FLOW_OFF_CHAR_2 = 18'h04000,
    TGT_TCR = 18'h08000,
    TGT_TLR = 18'h10000,
    TGT_FRDY = 18'h20000
  } urs_target_t;

  // Host bus pins, all active low except address and data
  typedef struct packed {
    logic [2:0] addr;
    logic chanASelectN;
    logic chanBSelectN;
    logic readN;
    logic writeN;
    logic [7:0] data;
  } urs_bus_pins_t;

  // Per-channel configuration held by the bank
  typedef struct packed {
    logic [15:0] baudDivisor;
    logic [7:0] irqEnable;
    logic [7:0] fifoControl;
    logic [7:0] lineControl;
    logic [7:0] modemControl;
    logic [7:0] enhancedFeatures;
    logic [7:0] flowOnChar1;
    logic [7:0] flowOnChar2;
    logic [7:0] flowOffChar1;
    logic [7:0] flowOffChar2;
    logic [7:0] flowThresholdControl;
    logic [7:0] fifoTriggerLevels;
    logic [7:0] scratchPad;
  } urs_config_t;

  // Per-channel status from the datapath
  typedef struct packed {
    logic [7:0] rxHolding;
    logic [7:0] irqIdentify;
    logic [7:0] lineStatus;
    logic [7:0] modemStatus;
  } urs_status_t;

  // Whole state of the register map
  typedef struct packed {
    urs_bus_pins_t busS1;
    urs_bus_pins_t busS2;
    urs_bus_pins_t busS3;
    urs_config_t [1:0] cfg;
    logic [7:0] readData;
    logic readOe;
    logic [1:0] rxPop;
    logic [1:0] txPush;
    logic [1:0] fifoCtlStrobe;
    logic [7:0] txByte;
  } urs_state_t;

endpackage : urs_pkg

//--- src/urs_register_map.sv
// Register select map for a dual UART: two independent register banks
// reached over an 8-bit strobed host bus.
// Assumes host pins are asynchronous to clock and the datapath status
// inputs are synchronous to clock.
`timescale 1ns/100ps
`default_nettype none

`include "urs_defs.svh"

// Notes on behaviour
// - The target register comes from the three address lines plus gating bits in other registers.
// - Offset 000 without divisor access reads the received byte and writes the transmit byte.
// - Offset 001 without divisor access reads and writes the interrupt enable register.
// - Offset 010 normally reads interrupt identification and writes the separate FIFO control.
// - Line control at 011 and modem control at 100 are readable and writable.
// - Offset 101 normally reads line status and a write there changes nothing.
// - Offset 110 normally reads modem status with no write target; 111 is a scratch byte.
// - Offsets 000 and 001 reach the divisor low and high bytes only while line control bit 7 is 1.
// - Enhanced features and the four flow characters are reached only while line control is 0xBF.
// - Threshold at 110 and trigger levels at 111 need enhanced bit 4 and modem control bit 6.
// - The FIFO ready summary reads only with both selects low, modem bit 2 set and no loopback.
// - Modem control bit 7 changes only while enhanced bit 4 is 1.
// - Enhanced bits of interrupt enable (7:4) and FIFO control (5:4) need enhanced bit 4.
module urs_register_map (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Host bus pins
  input wire urs_pkg::urs_bus_pins_t busPins,
  output var logic [7:0] busDataOut,
  output var logic busDataOe,
  // Datapath status per channel
  input wire urs_pkg::urs_status_t [1:0] chanStatus,
  input wire logic [1:0] rxFifoReady,
  input wire logic [1:0] txFifoReady,
  // Datapath controls per channel, with one transmit byte shared by both
  output var urs_pkg::urs_config_t [1:0] chanConfig,
  output var logic [1:0] rxPop,
  output var logic [1:0] txPush,
  output var logic [1:0] fifoCtlStrobe,
  output var logic [7:0] txByte
);
  import urs_pkg::*;

  urs_state_t st_r;
  urs_state_t st_nxt;

  // Target decode for one channel, highest priority first
  function automatic urs_target_t urs_decode(
    input logic [2:0] ofs,
    input urs_config_t c,
    input logic bothSel,
    input logic isWrite
  );
    logic extSet;
    logic divSet;
    logic trigSet;
    logic rdySet;
    urs_target_t t;
    extSet = (c.lineControl == `URS_LCR_EXT_KEY);
    divSet = c.lineControl[`URS_LCR_DIVISOR_BIT];
    trigSet = c.enhancedFeatures[`URS_EFR_ENH_BIT]
              && c.modemControl[`URS_MCR_TRIG_EN_BIT];
    rdySet = bothSel && c.modemControl[`URS_MCR_RDY_EN_BIT]
             && !c.modemControl[`URS_MCR_LOOP_BIT] && !isWrite;
    case (ofs)
      `URS_OFS_DATA: t = divSet ? TGT_DLL : TGT_DATA;
      `URS_OFS_IER: t = divSet ? TGT_DLH : TGT_IER;
      `URS_OFS_IIR: t = extSet ? TGT_EFR : TGT_IIR_FCR;
      `URS_OFS_LCR: t = TGT_LCR;
      `URS_OFS_MCR: t = extSet ? TGT_FLOW_ON_CHAR_1 : TGT_MCR;
      `URS_OFS_LSR: t = extSet ? TGT_FLOW_ON_CHAR_2 : TGT_LSR;
      `URS_OFS_MSR: begin
        if (extSet) begin
          t = TGT_FLOW_OFF_CHAR_1;
        end else if (trigSet) begin
          t = TGT_TCR;
        end else begin
          t = TGT_MSR;
        end
      end
      `URS_OFS_SPR: begin
        if (extSet) begin
          t = TGT_FLOW_OFF_CHAR_2;
        end else if (trigSet) begin
          t = TGT_TLR;
        end else if (rdySet) begin
          t = TGT_FRDY;
        end else begin
          t = TGT_SPR;
        end
      end
      default: t = TGT_DATA;
    endcase
    return t;
  endfunction : urs_decode

  // Merge a written byte, holding protected bits unless enhanced is on
  function automatic logic [7:0] urs_guard(
    input logic [7:0] oldVal,
    input logic [7:0] newVal,
    input logic [7:0] protMask,
    input logic enhOn
  );
    logic [7:0] keep;
    keep = enhOn ? 8'h00 : protMask;
    return (oldVal & keep) | (newVal & ~keep);
  endfunction : urs_guard

  // Next-state logic: pin sync, strobe edges, read and write decode
  always_comb begin
    logic rdStart;
    logic wrEnd;
    logic [1:0] rdSel;
    logic [1:0] wrSel;
    logic rdChan;
    logic enhOn;
    urs_target_t rdTgt;
    urs_target_t wrTgt;
    urs_config_t rc;
    urs_status_t rs;
    logic [7:0] wd;
    rdStart = 1'b0;
    wrEnd = 1'b0;
    rdSel = 2'h0;
    wrSel = 2'h0;
    rdChan = 1'b0;
    enhOn = 1'b0;
    rdTgt = TGT_DATA;
    wrTgt = TGT_DATA;
    rc = st_r.cfg[`URS_CHAN_A];
    rs = chanStatus[`URS_CHAN_A];
    wd = st_r.busS3.data;
    st_nxt = st_r;

    // Two-flop sync of every pin, third stage for edge detection
    st_nxt.busS1 = busPins;
    st_nxt.busS2 = st_r.busS1;
    st_nxt.busS3 = st_r.busS2;
    st_nxt.rxPop = 2'h0;
    st_nxt.txPush = 2'h0;
    st_nxt.fifoCtlStrobe = 2'h0;

    // Read is taken as the strobe goes active, write as it releases
    rdStart = !st_r.busS2.readN && st_r.busS3.readN;
    wrEnd = st_r.busS2.writeN && !st_r.busS3.writeN;
    rdSel = {!st_r.busS2.chanBSelectN, !st_r.busS2.chanASelectN};
    wrSel = {!st_r.busS3.chanBSelectN, !st_r.busS3.chanASelectN};

    // Read: channel A wins when both selects are low
    rdChan = !rdSel[`URS_CHAN_A];
    rc = st_r.cfg[rdChan];
    rs = chanStatus[rdChan];
    rdTgt = urs_decode(st_r.busS2.addr, rc, &rdSel, 1'b0);
    if (rdStart && (|rdSel)) begin
      st_nxt.readOe = 1'b1;
      case (rdTgt)
        TGT_DATA: begin
          st_nxt.readData = rs.rxHolding;
          st_nxt.rxPop[rdChan] = 1'b1;
        end
        TGT_IER: st_nxt.readData = rc.irqEnable;
        TGT_IIR_FCR: begin
          // Top two bits mirror the FIFO enable, no FIFO control storage read
          st_nxt.readData = {{2{rc.fifoControl[`URS_FCR_ENABLE_BIT]}},
                             rs.irqIdentify[5:0]};
        end
        TGT_LCR: st_nxt.readData = rc.lineControl;
        TGT_MCR: st_nxt.readData = rc.modemControl;
        TGT_LSR: st_nxt.readData = rs.lineStatus;
        TGT_MSR: st_nxt.readData = rs.modemStatus;
        TGT_SPR: st_nxt.readData = rc.scratchPad;
        TGT_DLL: st_nxt.readData = rc.baudDivisor[7:0];
        TGT_DLH: st_nxt.readData = rc.baudDivisor[15:8];
        TGT_EFR: st_nxt.readData = rc.enhancedFeatures;
        TGT_FLOW_ON_CHAR_1: st_nxt.readData = rc.flowOnChar1;
        TGT_FLOW_ON_CHAR_2: st_nxt.readData = rc.flowOnChar2;
        TGT_FLOW_OFF_CHAR_1: st_nxt.readData = rc.flowOffChar1;
        TGT_FLOW_OFF_CHAR_2: st_nxt.readData = rc.flowOffChar2;
        TGT_TCR: st_nxt.readData = rc.flowThresholdControl;
        TGT_TLR: st_nxt.readData = rc.fifoTriggerLevels;
        TGT_FRDY: begin
          st_nxt.readData = {`URS_FRDY_PAD, rxFifoReady,
                             `URS_FRDY_PAD, txFifoReady};
        end
        default: st_nxt.readData = `URS_RESET_BYTE;
      endcase
    end else if (st_r.busS2.readN) begin
      // Drive the bus only while the read strobe stands
      st_nxt.readOe = 1'b0;
    end

    // Write: both selects low writes the byte to both banks, each decoded by its own gating bits
    for (int c = 0; c < 2; c++) begin
      wrTgt = urs_decode(st_r.busS3.addr, st_r.cfg[c], &wrSel, 1'b1);
      enhOn = st_r.cfg[c].enhancedFeatures[`URS_EFR_ENH_BIT];
      if (wrEnd && wrSel[c]) begin
        case (wrTgt)
          TGT_DATA: begin
            st_nxt.txByte = wd;
            st_nxt.txPush[c] = 1'b1;
          end
          TGT_IER: begin
            st_nxt.cfg[c].irqEnable = urs_guard(st_r.cfg[c].irqEnable, wd,
              `URS_IER_ENH_MASK, enhOn);
          end
          TGT_IIR_FCR: begin
            // Clear bits act once through the strobe, never stored
            st_nxt.cfg[c].fifoControl = urs_guard(st_r.cfg[c].fifoControl,
              wd, `URS_FCR_ENH_MASK, enhOn) & ~`URS_FCR_SELFCLR_MASK;
            st_nxt.fifoCtlStrobe[c] = 1'b1;
          end
          TGT_LCR: st_nxt.cfg[c].lineControl = wd;
          TGT_MCR: begin
            st_nxt.cfg[c].modemControl = urs_guard(st_r.cfg[c].modemControl,
              wd, `URS_MCR_ENH_MASK, enhOn);
          end
          TGT_SPR: st_nxt.cfg[c].scratchPad = wd;
          TGT_DLL: st_nxt.cfg[c].baudDivisor[7:0] = wd;
          TGT_DLH: st_nxt.cfg[c].baudDivisor[15:8] = wd;
          TGT_EFR: st_nxt.cfg[c].enhancedFeatures = wd;
          TGT_FLOW_ON_CHAR_1: st_nxt.cfg[c].flowOnChar1 = wd;
          TGT_FLOW_ON_CHAR_2: st_nxt.cfg[c].flowOnChar2 = wd;
          TGT_FLOW_OFF_CHAR_1: st_nxt.cfg[c].flowOffChar1 = wd;
          TGT_FLOW_OFF_CHAR_2: st_nxt.cfg[c].flowOffChar2 = wd;
          TGT_TCR: st_nxt.cfg[c].flowThresholdControl = wd;
          TGT_TLR: st_nxt.cfg[c].fifoTriggerLevels = wd;
          // Status offsets have no write target
          default: st_nxt.cfg[c] = st_r.cfg[c];
        endcase
      end
    end
  end

  // State register; select and strobe pins idle high out of reset so no false edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.busS1.chanASelectN <= 1'b1;
      st_r.busS1.chanBSelectN <= 1'b1;
      st_r.busS1.readN <= 1'b1;
      st_r.busS1.writeN <= 1'b1;
      st_r.busS2.chanASelectN <= 1'b1;
      st_r.busS2.chanBSelectN <= 1'b1;
      st_r.busS2.readN <= 1'b1;
      st_r.busS2.writeN <= 1'b1;
      st_r.busS3.chanASelectN <= 1'b1;
      st_r.busS3.chanBSelectN <= 1'b1;
      st_r.busS3.readN <= 1'b1;
      st_r.busS3.writeN <= 1'b1;
      st_r.readData <= `URS_RESET_BYTE;
      st_r.txByte <= `URS_RESET_BYTE;
      for (int c = 0; c < 2; c++) begin
        st_r.cfg[c].baudDivisor <= `URS_RESET_DIVISOR;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign busDataOut = st_r.readData;
  assign busDataOe = st_r.readOe;
  assign chanConfig = st_r.cfg;
  assign rxPop = st_r.rxPop;
  assign txPush = st_r.txPush;
  assign fifoCtlStrobe = st_r.fifoCtlStrobe;
  assign txByte = st_r.txByte;

endmodule : urs_register_map

`default_nettype wire

//--- sim/urs_assertions.sv
// Port checks for the register select map; storage checks cover the channel A bank only, push checks both channels.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module urs_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Host bus
  input wire urs_pkg::urs_bus_pins_t busPins,
  input wire logic busDataOe,
  // Datapath side
  input wire urs_pkg::urs_config_t [1:0] chanConfig,
  input wire logic [1:0] rxPop,
  input wire logic [1:0] txPush,
  input wire logic [1:0] fifoCtlStrobe
);
  import urs_pkg::*;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Short names; pins see a two-flop synchroniser, so answers trail by three edges
  logic anySel;
  urs_config_t ca;
  assign anySel = !(busPins.chanASelectN && busPins.chanBSelectN);
  assign ca = chanConfig[0];
  // Bus timing and pulses
  a_read_answer: assert property ($fell(busPins.readN) && anySel |-> ##3 busDataOe)
    else $error("read answer late");
  a_oe_release: assert property ($rose(busPins.readN) && anySel |-> busDataOe [*3] ##1 !busDataOe)
    else $error("data enable release wrong");
  a_rx_pop: assert property (rxPop[0] |-> $rose(busDataOe) ##1 !rxPop[0])
    else $error("receive pop misplaced");
  a_tx_push: assert property (txPush != 2'h0 |=> txPush == 2'h0)
    else $error("transmit push too long");
  a_fcr_strobe: assert property (fifoCtlStrobe[0] |-> ca.fifoControl[2:1] == 2'h0 ##1 !fifoCtlStrobe[0])
    else $error("fifo control strobe wrong");
  // Gated and protected storage may only move while its gate is open
  a_mcr7_lock: assert property (!ca.enhancedFeatures[4] |=> $stable(ca.modemControl[7]))
    else $error("prescale bit moved while locked");
  a_enh_lock: assert property (!ca.enhancedFeatures[4] |=> $stable({ca.irqEnable[7:4], ca.fifoControl[5:4]}))
    else $error("enhanced bits moved while locked");
  a_div_gate: assert property (!ca.lineControl[7] |=> $stable(ca.baudDivisor))
    else $error("divisor moved without access bit");
  a_ext_gate: assert property (ca.lineControl != 8'hBF |=> $stable({ca.enhancedFeatures, ca.flowOnChar1, ca.flowOnChar2, ca.flowOffChar1, ca.flowOffChar2}))
    else $error("extended set moved without key");
  a_trig_gate: assert property (!(ca.enhancedFeatures[4] && ca.modemControl[6]) |=> $stable({ca.flowThresholdControl, ca.fifoTriggerLevels}))
    else $error("threshold or trigger moved while gated");
endmodule : urs_assertions
bind urs_register_map urs_assertions u_chk (.clock(clock), .rst_n(rst_n), .busPins(busPins),
  .busDataOe(busDataOe), .chanConfig(chanConfig), .rxPop(rxPop), .txPush(txPush),
  .fifoCtlStrobe(fifoCtlStrobe));
`default_nettype wire

//--- sim/urs_host_model.sv
// Host processor model for the strobed 8-bit register bus.
// Assumes the bench calls xfer for one transfer at a time.
`timescale 1ns/100ps
`default_nettype none
module urs_host_model (
  // Clock
  input wire logic clock,
  // Host bus pins
  output var urs_pkg::urs_bus_pins_t busPins
);
  import urs_pkg::*;
  // Idle bus: nothing selected, both strobes high
  initial begin
    busPins = {3'h0, 4'hF, 8'h00};
  end
  // Strobe and the gap after it span five edges, the deselect gap three, so the synchroniser never misses one
  task automatic xfer(input logic [1:0] selN, input logic [2:0] ofs, input logic [7:0] d,
                      input logic isWr);
    @(posedge clock);
    busPins.addr <= ofs;
    busPins.chanASelectN <= selN[0];
    busPins.chanBSelectN <= selN[1];
    busPins.data <= d;
    busPins.readN <= isWr;
    busPins.writeN <= !isWr;
    repeat (5) @(posedge clock);
    busPins.readN <= 1'b1;
    busPins.writeN <= 1'b1;
    repeat (5) @(posedge clock);
    // Released data shows the inverse, so a stale byte cannot pass
    busPins.chanASelectN <= 1'b1;
    busPins.chanBSelectN <= 1'b1;
    busPins.data <= ~d;
    repeat (3) @(posedge clock);
  endtask : xfer
endmodule : urs_host_model
`default_nettype wire

//--- sim/uart_register_select_map_tb.sv
// Self-checking bench for the register select map.
// Assumes the host model drives pins and reads retire queued expectations.
`timescale 1ns/100ps
`default_nettype none
module uart_register_select_map_tb;
  import urs_pkg::*;
  // Selects as {B, A}, active low
  localparam logic [1:0] SA = 2'b10;
  localparam logic [1:0] SB = 2'b01;
  localparam logic [1:0] SAB = 2'b00;
  localparam logic [1:0] SN = 2'b11;
  logic clock;
  logic rst_n;
  urs_bus_pins_t busPins;
  logic [7:0] busDataOut;
  logic [7:0] txByte;
  logic busDataOe;
  logic oeSeen = 1'b0;
  urs_status_t [1:0] chanStatus;
  urs_status_t s0;
  urs_status_t s1;
  urs_config_t [1:0] chanConfig;
  logic [1:0] rxFifoReady;
  logic [1:0] txFifoReady;
  logic [1:0] rxPop;
  logic [1:0] txPush;
  logic [1:0] fifoCtlStrobe;
  logic [7:0] expQ [$];
  logic [7:0] v [8];
  logic [15:0] dv;
  logic [31:0] lfsr = 32'h4303;
  int n_errors = 0;
  int cmp_count = 0;
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  urs_host_model host (.clock(clock), .busPins(busPins));
  urs_register_map dut (.clock(clock), .rst_n(rst_n), .busPins(busPins),
    .busDataOut(busDataOut), .busDataOe(busDataOe), .chanStatus(chanStatus),
    .rxFifoReady(rxFifoReady), .txFifoReady(txFifoReady), .chanConfig(chanConfig),
    .rxPop(rxPop), .txPush(txPush), .fifoCtlStrobe(fifoCtlStrobe), .txByte(txByte));
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [7:0] d);
    host.xfer(s, a, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [1:0] s, input logic [2:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.xfer(s, a, 8'h00, 1'b0);
  endtask : rd
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  // Every fresh read answer retires the oldest expectation; none queued is a fault
  always @(posedge clock) begin
    oeSeen <= busDataOe;
    if (busDataOe === 1'b1 && oeSeen !== 1'b1) begin
      if (expQ.size() == 0) chk(busDataOut, ~busDataOut);
      else chk(busDataOut, expQ.pop_front());
    end
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    chanStatus = '0;
    rxFifoReady = 2'h0;
    txFifoReady = 2'h0;
    repeat (16) @(posedge clock);
    // Random datapath status, steady for the run
    lfsr = step(lfsr);
    s0 = lfsr;
    lfsr = step(lfsr);
    s1 = lfsr;
    chanStatus <= {s1, s0};
    {rxFifoReady, txFifoReady} <= lfsr[5:2];
    rst_n <= 1'b1;
    rd(SA, 3'h0, s0.rxHolding);
    rd(SA, 3'h1, 8'h00);
    rd(SA, 3'h2, {2'h0, s0.irqIdentify[5:0]});
    rd(SA, 3'h3, 8'h00);
    rd(SA, 3'h5, s0.lineStatus);
    rd(SA, 3'h6, s0.modemStatus);
    $display("test 1 done");
    // Plain writes, refused targets and locked bits
    wr(SA, 3'h7, 8'h5A);
    wr(SA, 3'h1, 8'hFF);
    wr(SA, 3'h4, 8'hFF);
    wr(SA, 3'h5, 8'h11);
    wr(SA, 3'h6, 8'h22);
    wr(SA, 3'h2, 8'h31);
    wr(SA, 3'h0, 8'hC3);
    chk(txByte, 8'hC3);
    chk(chanConfig[0].fifoControl, 8'h01);
    rd(SA, 3'h7, 8'h5A);
    rd(SA, 3'h1, 8'h0F);
    rd(SA, 3'h4, 8'h7F);
    rd(SA, 3'h5, s0.lineStatus);
    rd(SA, 3'h6, s0.modemStatus);
    rd(SA, 3'h2, {2'h3, s0.irqIdentify[5:0]});
    $display("test 2 done");
    lfsr = step(lfsr);
    dv = lfsr[15:0];
    wr(SA, 3'h3, 8'h80);
    wr(SA, 3'h0, dv[7:0]);
    wr(SA, 3'h1, dv[15:8]);
    rd(SA, 3'h0, dv[7:0]);
    rd(SA, 3'h1, dv[15:8]);
    rd(SA, 3'h3, 8'h80);
    wr(SA, 3'h3, 8'h03);
    rd(SA, 3'h1, 8'h0F);
    $display("test 3 done");
    // Keyed extended set over the modem control through scratch offsets
    wr(SA, 3'h3, 8'hBF);
    wr(SA, 3'h2, 8'h10);
    for (int a = 4; a < 8; a++) begin
      lfsr = step(lfsr);
      v[a] = lfsr[7:0];
      wr(SA, a[2:0], v[a]);
    end
    for (int a = 4; a < 8; a++) rd(SA, a[2:0], v[a]);
    rd(SA, 3'h2, 8'h10);
    rd(SA, 3'h0, dv[7:0]);
    wr(SA, 3'h3, 8'h03);
    rd(SA, 3'h4, 8'h7F);
    // Enhanced bit 4 and modem bit 6 are both set now, so 111 reaches the trigger levels
    rd(SA, 3'h7, 8'h00);
    $display("test 4 done");
    // Enhanced functions on: unlocked bits, threshold and trigger, ready summary
    wr(SA, 3'h1, 8'hF5);
    wr(SA, 3'h4, 8'hC4);
    wr(SA, 3'h2, 8'h31);
    chk(chanConfig[0].fifoControl, 8'h31);
    rd(SA, 3'h1, 8'hF5);
    rd(SA, 3'h4, 8'hC4);
    wr(SA, 3'h6, 8'h9A);
    wr(SA, 3'h7, 8'h6B);
    rd(SA, 3'h6, 8'h9A);
    rd(SAB, 3'h7, 8'h6B);
    wr(SA, 3'h4, 8'h04);
    rd(SA, 3'h6, s0.modemStatus);
    rd(SAB, 3'h7, {2'h0, rxFifoReady, 2'h0, txFifoReady});
    rd(SA, 3'h7, 8'h5A);
    wr(SA, 3'h4, 8'h14);
    rd(SAB, 3'h7, 8'h5A);
    $display("test 5 done");
    // Second bank stands apart; unselected strobes do nothing
    rd(SB, 3'h7, 8'h00);
    rd(SB, 3'h5, s1.lineStatus);
    wr(SB, 3'h7, 8'hA5);
    host.xfer(SN, 3'h7, 8'hEE, 1'b1);
    host.xfer(SN, 3'h7, 8'h00, 1'b0);
    rd(SB, 3'h7, 8'hA5);
    rd(SA, 3'h7, 8'h5A);
    $display("test 6 done");
    for (int i = 0; i < 20 && expQ.size() > 0; i++) @(posedge clock);
    if (expQ.size() > 0) n_errors++;
    summarize();
  end
endmodule : uart_register_select_map_tb
`default_nettype wire
